// ==== logic/bitstream_converter_params.svh ====
`ifndef BITSTREAM_CONVERTER_PARAMS_SVH
`define BITSTREAM_CONVERTER_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define SAMPLE_PAIR_OFS 8'h00
`define CONTROL_OFS     8'h08
`define IRQ_MASK_OFS    8'h0C
`define IRQ_ENABLE_OFS  8'h10
`define IRQ_DISABLE_OFS 8'h14
`define IRQ_CLEAR_OFS   8'h18
`define IRQ_STATUS_OFS  8'h1C

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define ENABLE_BIT      31
`define SWAP_BIT        30
`define READY_BIT       29
`define UNDERRUN_BIT    28
`define SAMPLE_PAIR_RST 32'h00000000
`define CONTROL_RST     32'h00000000
`define IRQ_MASK_RST    2'h0

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define ACLK_KHZ        250000
`define CONV_CLK_KHZ    12288
`define CONV_DIV        (`ACLK_KHZ / `CONV_CLK_KHZ)
`define CONV_PER_SAMPLE 256
`define OVERSAMPLE      128
`define CONV_PER_STEP   (`CONV_PER_SAMPLE / `OVERSAMPLE)

// ----------------------------------------------------------------------------
// Bus answers and datapath scaling
// ----------------------------------------------------------------------------
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`define CIC_SHIFT       21
`define SD_FULL_SCALE   32'sh00008000

`endif

// ==== logic/bitstream_converter_pkg.sv ====
package bitstream_converter_pkg;

  typedef logic signed [15:0] sample_t;
  typedef logic signed [23:0] comb_t;
  typedef logic signed [47:0] integ_t;
  typedef logic signed [31:0] loop_t;
  typedef logic [1:0]         resp_t;

endpackage : bitstream_converter_pkg

// ==== logic/sd_channel.sv ====
`timescale 1ns/1ps
`include "bitstream_converter_params.svh"

module sd_channel
  import bitstream_converter_pkg::*;
(
  input  wire logic    aclk,
  input  wire logic    aresetn,
  input  wire logic    run,
  input  wire logic    load,
  input  wire sample_t sample,
  input  wire logic    step,
  output logic         bit_out,
  output logic         bit_inv_out
);

  typedef struct packed {
    sample_t        x1;
    sample_t        x2;
    logic [3:0][23:0] comb_d;
    comb_t          impulse;
    logic [3:0][47:0] integ;
    logic [2:0][31:0] loop_acc;
    logic           q;
    logic           bit_out;
    logic           bit_inv_out;
  } chan_s;

  chan_s s;
  chan_s next_s;

  always_comb begin
    logic signed [19:0] fir;
    comb_t  c;
    integ_t acc;
    loop_t  u;
    loop_t  fb;
    loop_t  e;
    fir = 20'sh00000;
    c = 24'sh000000;
    acc = 48'sh000000000000;
    u = 32'sh00000000;
    fb = 32'sh00000000;
    e = 32'sh00000000;
    next_s = s;
    if (!run) begin
      next_s = '0;
    end else begin
      if (load) begin
        // Droop equaliser with taps -1/8, 10/8, -1/8 and unity DC gain.
        fir = 20'((20'(s.x1) * 20'sh0000A - 20'(sample) - 20'(s.x2)) >>> 3);
        next_s.x1 = sample;
        next_s.x2 = s.x1;
        c = 24'(fir);
        for (int k = 0; k < 4; k++) begin
          next_s.comb_d[k] = c;
          c = c - comb_t'(s.comb_d[k]);
        end
        next_s.impulse = c;
      end
      if (step) begin
        // Zero stuffing: the comb output enters once, then zeros follow.
        acc = integ_t'(s.impulse);
        next_s.impulse = load ? next_s.impulse : 24'sh000000;
        for (int k = 0; k < 4; k++) begin
          acc = integ_t'(s.integ[k]) + acc;
          next_s.integ[k] = acc;
        end
        // Scale so that full scale lands near 38/128 and 90/128 density.
        u = 32'((acc >>> `CIC_SHIFT) * 48'sh00000000000D) >>> 5;
        fb = s.q ? `SD_FULL_SCALE : -`SD_FULL_SCALE;
        e = loop_t'(s.loop_acc[0]) + (u - fb);
        next_s.loop_acc[0] = e;
        e = loop_t'(s.loop_acc[1]) + ((e >>> 2) - fb);
        next_s.loop_acc[1] = e;
        e = loop_t'(s.loop_acc[2]) + ((e >>> 3) - fb);
        next_s.loop_acc[2] = e;
        next_s.q = (e >= 0);
        next_s.bit_out = ~next_s.q;
        next_s.bit_inv_out = next_s.q;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign bit_out = s.bit_out;
  assign bit_inv_out = s.bit_inv_out;

endmodule : sd_channel

// ==== logic/bitstream_converter.sv ====
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "bitstream_converter_params.svh"

module bitstream_converter
  import bitstream_converter_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             irq,
  output logic             dma_request,
  output logic             left_bitstream_out,
  output logic             right_bitstream_out,
  output logic             left_inverted_bitstream_out,
  output logic             right_inverted_bitstream_out
);

  localparam logic [4:0] conv_div_last = 5'(`CONV_DIV - 1);
  localparam logic [7:0] sample_last   = 8'(`CONV_PER_SAMPLE - 1);
  localparam logic [7:0] step_mask     = 8'(`CONV_PER_STEP - 1);
  localparam logic [31:0] control_rst  = `CONTROL_RST;

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        aw_held;
    logic [7:0]  aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    resp_t       bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    resp_t       rresp;
    logic [31:0] sample_pair;
    logic        enable;
    logic        swap;
    logic [1:0]  mask;
    logic        underrun;
    logic        ready_ack;
    logic        pending;
    sample_t     pend_left;
    sample_t     pend_right;
    sample_t     left;
    sample_t     right;
    logic [4:0]  div_cnt;
    logic [7:0]  conv_cnt;
    logic        step;
    logic        load;
    logic        irq;
    logic        dma_request;
  } top_s;

  top_s s;
  top_s next_s;

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic logic [31:0] strobe_merge(input logic [31:0] old_value,
                                               input logic [31:0] new_value,
                                               input logic [3:0]  strb);
    logic [31:0] r;
    r = old_value;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = new_value[b*8 +: 8];
      end
    end
    return r;
  endfunction : strobe_merge

  // Status bits as software sees them: {ready, underrun}.
  function automatic logic [1:0] status_bits(input top_s t);
    logic ready;
    ready = t.enable & ~t.pending & ~t.ready_ack;
    return {ready, t.underrun};
  endfunction : status_bits

  // --------------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------------
  always_comb begin
    logic        commit;
    logic        reading;
    logic [31:0] wval;
    logic [1:0]  flag_clear;
    logic [1:0]  ones;
    logic        conv_tick;
    logic        boundary;
    logic        ready_level;
    logic [1:0]  cur_status;
    commit = 1'b0;
    reading = 1'b0;
    wval = 32'h00000000;
    flag_clear = 2'h0;
    ones = 2'h0;
    conv_tick = 1'b0;
    boundary = 1'b0;
    ready_level = 1'b0;
    cur_status = status_bits(s);
    next_s = s;
    next_s.step = 1'b0;
    next_s.load = 1'b0;

    // Write address and data are taken independently, in either order.
    if (s_axi_awvalid && s.awready) begin
      next_s.aw_held = 1'b1;
      next_s.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wready) begin
      next_s.w_held = 1'b1;
      next_s.w_data = s_axi_wdata;
      next_s.w_strb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end

    // Conversion tick divider and sample period counter.
    if (s.enable) begin
      if (s.div_cnt == conv_div_last) begin
        next_s.div_cnt = 5'h00;
        conv_tick = 1'b1;
      end else begin
        next_s.div_cnt = s.div_cnt + 5'h01;
      end
      if (conv_tick) begin
        next_s.conv_cnt = s.conv_cnt + 8'h01;
        next_s.step = ((s.conv_cnt & step_mask) == step_mask);
        boundary = (s.conv_cnt == sample_last);
      end
    end else begin
      next_s.div_cnt = 5'h00;
      next_s.conv_cnt = 8'h00;
    end

    // At each sample boundary a waiting pair is consumed, else underrun.
    if (boundary) begin
      if (s.pending) begin
        next_s.left = s.pend_left;
        next_s.right = s.pend_right;
        next_s.load = 1'b1;
        next_s.pending = 1'b0;
        next_s.ready_ack = 1'b0;
      end else begin
        next_s.left = 16'sh0000;
        next_s.right = 16'sh0000;
        next_s.load = 1'b1;
      end
    end

    // Register reads; a read of the status register clears its flags.
    if (s_axi_arvalid && s.arready) begin
      reading = 1'b1;
      next_s.rvalid = 1'b1;
      next_s.rresp = `RESP_OKAY;
      next_s.rdata = 32'h00000000;
      if (s_axi_araddr == `SAMPLE_PAIR_OFS) begin
        next_s.rdata = s.sample_pair;
      end else if (s_axi_araddr == `CONTROL_OFS) begin
        next_s.rdata[`ENABLE_BIT] = s.enable;
        next_s.rdata[`SWAP_BIT] = s.swap;
      end else if (s_axi_araddr == `IRQ_MASK_OFS) begin
        next_s.rdata[`READY_BIT -: 2] = s.mask;
      end else if (s_axi_araddr == `IRQ_STATUS_OFS) begin
        next_s.rdata[`READY_BIT -: 2] = status_bits(s);
        flag_clear = 2'h3;
      end else if (s_axi_araddr == `IRQ_ENABLE_OFS || s_axi_araddr == `IRQ_DISABLE_OFS
                   || s_axi_araddr == `IRQ_CLEAR_OFS) begin
        next_s.rdata = 32'h00000000;
      end else begin
        next_s.rresp = `RESP_SLVERR;
      end
    end

    // A write commits once both address and data are held.
    commit = s.aw_held && s.w_held && !s.bvalid;
    if (commit) begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = `RESP_OKAY;
      wval = strobe_merge(32'h00000000, s.w_data, s.w_strb);
      ones = wval[`READY_BIT -: 2];
      if (s.aw_addr == `SAMPLE_PAIR_OFS) begin
        next_s.sample_pair = strobe_merge(s.sample_pair, s.w_data, s.w_strb);
        next_s.pending = 1'b1;
        next_s.ready_ack = 1'b0;
        if (s.swap) begin
          next_s.pend_left = sample_t'(next_s.sample_pair[31:16]);
          next_s.pend_right = sample_t'(next_s.sample_pair[15:0]);
        end else begin
          next_s.pend_left = sample_t'(next_s.sample_pair[15:0]);
          next_s.pend_right = sample_t'(next_s.sample_pair[31:16]);
        end
      end else if (s.aw_addr == `CONTROL_OFS) begin
        if (s.w_strb[3]) begin
          next_s.enable = s.w_data[`ENABLE_BIT];
          next_s.swap = s.w_data[`SWAP_BIT];
        end
      end else if (s.aw_addr == `IRQ_ENABLE_OFS) begin
        next_s.mask = s.mask | ones;
      end else if (s.aw_addr == `IRQ_DISABLE_OFS) begin
        next_s.mask = s.mask & ~ones;
      end else if (s.aw_addr == `IRQ_CLEAR_OFS) begin
        flag_clear = flag_clear | ones;
      end else if (s.aw_addr == `IRQ_MASK_OFS || s.aw_addr == `IRQ_STATUS_OFS) begin
        next_s.bresp = `RESP_OKAY;
      end else begin
        next_s.bresp = `RESP_SLVERR;
      end
    end

    // Clearing the ready flag only hides it until the next pair is wanted.
    if (flag_clear[1] && cur_status[1]) begin
      next_s.ready_ack = 1'b1;
    end
    if (flag_clear[0]) begin
      next_s.underrun = 1'b0;
    end
    // A new underrun wins over a clear in the same cycle.
    if (boundary && !s.pending) begin
      next_s.underrun = 1'b1;
    end

    // Disabling stops conversion and drops any waiting pair.
    if (!next_s.enable) begin
      next_s.pending = 1'b0;
      next_s.ready_ack = 1'b0;
    end

    ready_level = next_s.enable & ~next_s.pending;
    next_s.dma_request = ready_level;
    next_s.irq = |(status_bits(next_s) & next_s.mask);

    // Ready outputs for the next cycle.
    next_s.awready = !next_s.aw_held && !next_s.bvalid;
    next_s.wready = !next_s.w_held && !next_s.bvalid;
    next_s.arready = !next_s.rvalid && !reading;
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.sample_pair <= `SAMPLE_PAIR_RST;
      s.mask <= `IRQ_MASK_RST;
      s.enable <= control_rst[`ENABLE_BIT];
      s.swap <= control_rst[`SWAP_BIT];
    end else begin
      s <= next_s;
    end
  end

  // --------------------------------------------------------------------------
  // Channel datapaths
  // --------------------------------------------------------------------------
  sd_channel left_channel (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .run         (s.enable),
    .load        (s.load),
    .sample      (s.left),
    .step        (s.step),
    .bit_out     (left_bitstream_out),
    .bit_inv_out (left_inverted_bitstream_out)
  );

  sd_channel right_channel (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .run         (s.enable),
    .load        (s.load),
    .sample      (s.right),
    .step        (s.step),
    .bit_out     (right_bitstream_out),
    .bit_inv_out (right_inverted_bitstream_out)
  );

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign s_axi_awready = s.awready;
  assign s_axi_wready  = s.wready;
  assign s_axi_bvalid  = s.bvalid;
  assign s_axi_bresp   = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid  = s.rvalid;
  assign s_axi_rdata   = s.rdata;
  assign s_axi_rresp   = s.rresp;
  assign irq           = s.irq;
  assign dma_request   = s.dma_request;

endmodule : bitstream_converter

// ==== tb/bitstream_converter_checker.sv ====
`timescale 1ns/1ps
`include "bitstream_converter_params.svh"

module bitstream_converter_checker
  import bitstream_converter_pkg::*;
(
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  input wire logic       irq,
  input wire logic       dma_request,
  input wire logic       left_bitstream_out,
  input wire logic       right_bitstream_out,
  input wire logic       left_inverted_bitstream_out,
  input wire logic       right_inverted_bitstream_out
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_reset_quiet: assert property ($rose(aresetn) |-> !irq && !dma_request && !s_axi_bvalid)
    else $error("outputs not idle after reset");
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:3] s_axi_bvalid) else $error("write response late");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  chk_bvalid_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not retired");
  chk_rvalid_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data not retired");
  chk_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken with data pending");
  chk_inv_pair: assert property (!(left_bitstream_out && left_inverted_bitstream_out)
    && !(right_bitstream_out && right_inverted_bitstream_out)) else $error("outputs not inverse");
  chk_pair_taken: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready && s_axi_awaddr == `SAMPLE_PAIR_OFS |-> ##[1:3] !dma_request)
    else $error("request stays up after pair write");
  chk_step_rate: assert property ($changed(left_bitstream_out)
    && (left_bitstream_out || left_inverted_bitstream_out) |=> ($stable(left_bitstream_out)
    || !left_bitstream_out && !left_inverted_bitstream_out) [*8])
    else $error("bitstream faster than step rate");

  cover property (dma_request && s_axi_awvalid);
  cover property (irq);
  cover property ($rose(right_bitstream_out));
endmodule : bitstream_converter_checker

bind bitstream_converter bitstream_converter_checker bitstream_converter_checker_i (
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .irq, .dma_request, .left_bitstream_out,
  .right_bitstream_out, .left_inverted_bitstream_out, .right_inverted_bitstream_out
);

// ==== tb/bus_host_model.sv ====
`timescale 1ns/1ps
`include "bitstream_converter_params.svh"

module bus_host_model (
  input  wire logic        aclk,
  input  wire logic        dma_on,
  input  wire logic [31:0] dma_word,
  input  wire logic        dma_request,
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready,
  output logic             hang
);
  logic [1:0] dma_resp;

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && !awvalid && !wvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (n == 200) hang = 1'b1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      else if (!arvalid && rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (n == 200) hang = 1'b1;
  endtask : rd

  // The DMA side answers each request with the next pair well inside the sample window.
  initial begin
    {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready, hang} = '0;
    forever begin
      @(posedge aclk);
      if (dma_on && dma_request) wr(`SAMPLE_PAIR_OFS, dma_word, dma_resp);
    end
  end
endmodule : bus_host_model

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
`include "bitstream_converter_params.svh"

module testbench;
  localparam logic [31:0] READY = 32'h1 << `READY_BIT;
  localparam logic [31:0] UNDER = 32'h1 << `UNDERRUN_BIT;
  localparam logic [31:0] ENAB  = 32'h1 << `ENABLE_BIT;
  localparam logic [31:0] SWAP  = 32'h1 << `SWAP_BIT;
  logic        aclk, aresetn, dma_on, irq, dma_request, lbit, rbit, linv, rinv, hang;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, dma_word, rnd, m;
  logic [1:0]  bresp, rresp;
  logic [7:0]  offs [7];
  int          failures, samples_checked;

  bitstream_converter bitstream_converter_i (
    .aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .irq, .dma_request, .left_bitstream_out(lbit),
    .right_bitstream_out(rbit), .left_inverted_bitstream_out(linv),
    .right_inverted_bitstream_out(rinv));

  bus_host_model bus_host_model_i (
    .aclk, .dma_on, .dma_word, .dma_request, .awaddr, .awvalid, .awready, .wdata, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .hang);

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  // Ones among 128 steps: positive input gives fewer ones, linear in the sample.
  function automatic int exp_ones(input logic signed [15:0] s);
    return 64 - (int'(s) * 26) / 32768;
  endfunction : exp_ones

  task automatic test_done;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic w(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    bus_host_model_i.wr(a, d, r);
    check({30'h0, r}, {30'h0, `RESP_OKAY}, "write response");
  endtask : w

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string what);
    logic [31:0] d;
    logic [1:0]  r;
    bus_host_model_i.rd(a, d, r);
    check(d, e, what);
  endtask : rd_chk

  task automatic pin_chk(input logic got, input logic exp, input string what);
    check({31'h0, got}, {31'h0, exp}, what);
  endtask : pin_chk

  task automatic density(input logic signed [15:0] ls, input logic signed [15:0] rs);
    int l, r, x;
    l = 0;
    r = 0;
    x = 0;
    // Seven sample periods let the equaliser and interpolator settle on the new pair.
    repeat (35840) @(posedge aclk);
    repeat (5120) begin
      @(posedge aclk);
      l += int'(lbit === 1'b1);
      r += int'(rbit === 1'b1);
      x += int'(lbit === linv || rbit === rinv);
    end
    samples_checked += 2;
    if (x != 0 || l / 40 < exp_ones(ls) - 8 || l / 40 > exp_ones(ls) + 8 ||
        r / 40 < exp_ones(rs) - 8 || r / 40 > exp_ones(rs) + 8) begin
      failures++;
      $display("MISMATCH t=%0t ones density left %0d right %0d, not inverse %0d", $time,
               l / 40, r / 40, x);
    end
  endtask : density

  always @(posedge aclk) if (hang === 1'b1) begin
    failures++;
    $display("MISMATCH t=%0t bus handshake timed out", $time);
    test_done();
  end

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    offs = '{`SAMPLE_PAIR_OFS, `CONTROL_OFS, `IRQ_MASK_OFS, `IRQ_ENABLE_OFS,
             `IRQ_DISABLE_OFS, `IRQ_CLEAR_OFS, `IRQ_STATUS_OFS};
    {aresetn, dma_on, dma_word, failures, samples_checked, m} = '0;
    rnd = 32'h025365B4;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (offs[i]) rd_chk(offs[i], 32'h0, "reset value");
    bus_host_model_i.rd(8'h04, d, r);
    check({30'h0, r}, {30'h0, `RESP_SLVERR}, "unmapped response");
    w(`IRQ_MASK_OFS, 32'hFFFFFFFF);
    rd_chk(`IRQ_MASK_OFS, 32'h0, "read-only mask");
    repeat (3) begin
      rnd = lfsr(rnd);
      w(`IRQ_ENABLE_OFS, rnd);
      m = m | (rnd & (READY | UNDER));
      rnd = lfsr(rnd);
      w(`IRQ_DISABLE_OFS, rnd);
      m = m & ~rnd;
      rd_chk(`IRQ_MASK_OFS, m, "mask after set and clear");
    end
    w(`IRQ_DISABLE_OFS, READY | UNDER);
    w(`IRQ_ENABLE_OFS, READY);
    w(`CONTROL_OFS, ENAB);
    repeat (3) @(posedge aclk);
    pin_chk(dma_request, 1'b1, "pair wanted after enable");
    pin_chk(irq, 1'b1, "ready interrupt");
    rd_chk(`IRQ_STATUS_OFS, READY, "ready flag");
    rd_chk(`IRQ_STATUS_OFS, 32'h0, "status after read");
    repeat (2) @(posedge aclk);
    pin_chk(irq, 1'b0, "interrupt after read");
    w(`SAMPLE_PAIR_OFS, 32'h0);
    repeat (2) @(posedge aclk);
    pin_chk(dma_request, 1'b0, "request with pair pending");
    rd_chk(`IRQ_STATUS_OFS, 32'h0, "ready low with pair pending");
    for (n = 0; n < 6000 && dma_request !== 1'b1; n++) @(posedge aclk);
    if (n == 6000) begin
      failures++;
      $display("MISMATCH t=%0t pair request never returned", $time);
      test_done();
    end
    repeat (5200) @(posedge aclk);
    w(`IRQ_DISABLE_OFS, READY);
    w(`IRQ_ENABLE_OFS, UNDER);
    repeat (2) @(posedge aclk);
    pin_chk(irq, 1'b1, "underrun interrupt");
    w(`IRQ_DISABLE_OFS, READY | UNDER);
    repeat (2) @(posedge aclk);
    pin_chk(irq, 1'b0, "all sources masked");
    w(`IRQ_CLEAR_OFS, UNDER);
    w(`IRQ_ENABLE_OFS, UNDER);
    repeat (2) @(posedge aclk);
    pin_chk(irq, 1'b0, "underrun request cleared");
    rd_chk(`IRQ_STATUS_OFS, READY, "only ready after clear");
    w(`IRQ_DISABLE_OFS, READY | UNDER);
    @(posedge aclk);
    dma_word <= 32'h80007FFF;
    dma_on   <= 1'b1;
    density(16'sh7FFF, -16'sh8000);
    @(posedge aclk);
    dma_on <= 1'b0;
    repeat (20) @(posedge aclk);
    w(`CONTROL_OFS, 32'h0);
    w(`CONTROL_OFS, ENAB | SWAP);
    @(posedge aclk);
    dma_on <= 1'b1;
    density(-16'sh8000, 16'sh7FFF);
    @(posedge aclk);
    dma_on <= 1'b0;
    repeat (20) @(posedge aclk);
    w(`CONTROL_OFS, 32'h0);
    repeat (3) @(posedge aclk);
    check({28'h0, lbit, rbit, linv, rinv}, 32'h0, "outputs when disabled");
    repeat (3) begin
      rnd = lfsr(rnd);
      w(`SAMPLE_PAIR_OFS, rnd);
      rd_chk(`SAMPLE_PAIR_OFS, rnd, "sample pair readback");
    end
    test_done();
  end
endmodule : testbench
